/* File: som_defs.svh */
// constants for the sense output multiplexer control
//
// What this block does
// - the negative comparator feedback is high while the amplifier level is above the threshold, low otherwise.
// - that feedback has no hysteresis and follows every crossing of the threshold.
// - channel-4 high, low and negative feedbacks reach the microcores with no register between.
// - each pin has a 2-bit gain code: 00 is 1.33, 01 is 2.0, 10 is 3.0, 11 is 5.33.
// - pin a, when enabled, routes 000 to channel 1, 001 to channel 3, 101 to the 2.5 V reference; others are reserved.
// - pin b, when enabled, routes 000 to channel 2, 001 to channel 4, 101 to the 2.5 V reference; others are reserved.
// - a pin whose enable bit is 0 is high impedance whatever its select code.
// - each pin's select code comes from a 3-bit source field of its own configuration register.
// - each configuration register also holds its own pin's gain code next to the enable bit, above the source field.
// - only the microcores write source, enable and gain of both pins.
`ifndef SOM_DEFS_SVH
`define SOM_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define SOM_CFG_OFFSET 9'h1aa
`define SOM_CFG_RESET 16'h0000

// ****************************************************************
// field layout of each configuration register
// ****************************************************************
`define SOM_SRC_LSB 0
`define SOM_SRC_MSB 2
`define SOM_EN_BIT 3
`define SOM_GAIN_LSB 4
`define SOM_GAIN_MSB 5
`define SOM_CFG_USED_MASK 16'h003f

// ****************************************************************
// source select codes
// ****************************************************************
`define SOM_SEL_CUR_LOW 3'h0
`define SOM_SEL_CUR_HIGH 3'h1
`define SOM_SEL_REF 3'h5

// ****************************************************************
// gain codes
// ****************************************************************
`define SOM_GAIN_X1P33 2'h0
`define SOM_GAIN_X2P0 2'h1
`define SOM_GAIN_X3P0 2'h2
`define SOM_GAIN_X5P33 2'h3

`endif

/* File: som_pkg.sv */
// types shared by the sense output multiplexer control
package som_pkg;

   // ****************************************************************
   // analog routing of one output pin
   // ****************************************************************
   typedef enum logic [1:0] {
      SOM_ROUTE_OFF,
      SOM_ROUTE_CUR_LOW,
      SOM_ROUTE_CUR_HIGH,
      SOM_ROUTE_REF
   } som_route_e;

   typedef logic [1:0] som_gain_t;
   typedef logic [15:0] som_cfg_t;

endpackage : som_pkg

/* File: som_pin_if.sv */
// carrier between the register file and one pin channel
`timescale 1ns/1ps
`default_nettype none
interface som_pin_if;
   som_pkg::som_cfg_t cfg;
   som_pkg::som_route_e route;
   som_pkg::som_gain_t gain;
   logic oe_n;
   logic reserved_sel;

   modport ctrl (
      output cfg,
      input route,
      input gain,
      input oe_n,
      input reserved_sel
   );
   modport chan (
      input cfg,
      output route,
      output gain,
      output oe_n,
      output reserved_sel
   );
endinterface : som_pin_if
`default_nettype wire

/* File: som_pin_channel.sv */
// one output pin: decodes its configuration into routing controls
`timescale 1ns/1ps
`default_nettype none
`include "som_defs.svh"
module som_pin_channel (
   input wire logic i_clk,
   input wire logic i_resetn,
   som_pin_if.chan pin
);

   // ****************************************************************
   // decode
   // ****************************************************************
   logic [2:0] sel;
   logic en;
   som_pkg::som_route_e route_next;

   assign sel = pin.cfg[`SOM_SRC_MSB:`SOM_SRC_LSB];
   assign en = pin.cfg[`SOM_EN_BIT];

   always_comb begin
      route_next = som_pkg::SOM_ROUTE_OFF;
      if (en) begin
         unique case (sel)
            `SOM_SEL_CUR_LOW: route_next = som_pkg::SOM_ROUTE_CUR_LOW;
            `SOM_SEL_CUR_HIGH: route_next = som_pkg::SOM_ROUTE_CUR_HIGH;
            `SOM_SEL_REF: route_next = som_pkg::SOM_ROUTE_REF;
            // reserved codes leave the pin floating rather than guess
            default: route_next = som_pkg::SOM_ROUTE_OFF;
         endcase
      end
   end

   // ****************************************************************
   // registered pin controls
   // ****************************************************************
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin.route <= som_pkg::SOM_ROUTE_OFF;
         pin.oe_n <= 1'b1;
         pin.reserved_sel <= 1'b0;
      end else begin
         pin.route <= route_next;
         pin.oe_n <= (route_next == som_pkg::SOM_ROUTE_OFF);
         pin.reserved_sel <= en && (route_next == som_pkg::SOM_ROUTE_OFF);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin.gain <= `SOM_GAIN_X1P33;
      end else begin
         pin.gain <= pin.cfg[`SOM_GAIN_MSB:`SOM_GAIN_LSB];
      end
   end

endmodule : som_pin_channel
`default_nettype wire

/* File: som_top.sv */
// sense output multiplexer control: config registers, pins, comparator
`timescale 1ns/1ps
`default_nettype none
`include "som_defs.svh"
module som_top #(
   parameter int LEVEL_W = 12
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   // microcore configuration port
   input wire logic i_core_wr_en,
   input wire logic i_core_rd_en,
   input wire logic i_core_sel_b,
   input wire logic [8:0] i_core_addr,
   input wire logic [15:0] i_core_wr_data,
   output logic [15:0] o_core_rd_data,
   output logic o_core_rd_valid,
   // negative current comparator levels
   input wire logic [LEVEL_W-1:0] i_diff_amp_level,
   input wire logic [LEVEL_W-1:0] i_neg_dac_level,
   // channel-4 positive comparators
   input wire logic i_chan_four_high_cmp,
   input wire logic i_chan_four_low_cmp,
   // feedbacks to the microcores
   output logic o_chan_four_high_feedback,
   output logic o_chan_four_low_feedback,
   output logic o_chan_four_negative_feedback,
   // analog pin a controls
   output logic [1:0] o_sense_out_pin_a_route,
   output logic [1:0] o_sense_out_pin_a_gain,
   output logic o_sense_out_pin_a_oe_n,
   output logic o_sense_out_pin_a_reserved,
   // analog pin b controls
   output logic [1:0] o_sense_out_pin_b_route,
   output logic [1:0] o_sense_out_pin_b_gain,
   output logic o_sense_out_pin_b_oe_n,
   output logic o_sense_out_pin_b_reserved
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   // unused bits are kept at zero so reads show them as zero
   function automatic som_pkg::som_cfg_t som_cfg_clean(
      input som_pkg::som_cfg_t raw
   );
      som_cfg_clean = raw & `SOM_CFG_USED_MASK;
   endfunction : som_cfg_clean

   function automatic logic som_hit(
      input logic [8:0] addr
   );
      som_hit = (addr == `SOM_CFG_OFFSET);
   endfunction : som_hit

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   som_pkg::som_cfg_t cfg_a_reg;
   som_pkg::som_cfg_t cfg_b_reg;
   logic wr_a;
   logic wr_b;

   // both registers share one offset; the core picks the pin by sel_b
   assign wr_a = i_core_wr_en && som_hit(i_core_addr) && !i_core_sel_b;
   assign wr_b = i_core_wr_en && som_hit(i_core_addr) && i_core_sel_b;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_a_reg <= `SOM_CFG_RESET;
      end else if (wr_a) begin
         cfg_a_reg <= som_cfg_clean(i_core_wr_data);
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_b_reg <= `SOM_CFG_RESET;
      end else if (wr_b) begin
         cfg_b_reg <= som_cfg_clean(i_core_wr_data);
      end
   end

   // ****************************************************************
   // read back
   // ****************************************************************
   logic [15:0] rd_data_next;

   always_comb begin
      rd_data_next = 16'h0000;
      if (som_hit(i_core_addr)) begin
         rd_data_next = i_core_sel_b ? cfg_b_reg : cfg_a_reg;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_core_rd_data <= 16'h0000;
         o_core_rd_valid <= 1'b0;
      end else begin
         o_core_rd_valid <= i_core_rd_en;
         if (i_core_rd_en) begin
            o_core_rd_data <= rd_data_next;
         end
      end
   end

   // ****************************************************************
   // pin channels
   // ****************************************************************
   som_pin_if pin_a ();
   som_pin_if pin_b ();

   assign pin_a.cfg = cfg_a_reg;
   assign pin_b.cfg = cfg_b_reg;

   som_pin_channel u_pin_a (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .pin(pin_a)
   );

   som_pin_channel u_pin_b (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .pin(pin_b)
   );

   // controls below come straight from the channel flip-flops
   assign o_sense_out_pin_a_route = pin_a.route;
   assign o_sense_out_pin_a_gain = pin_a.gain;
   assign o_sense_out_pin_a_oe_n = pin_a.oe_n;
   assign o_sense_out_pin_a_reserved = pin_a.reserved_sel;
   assign o_sense_out_pin_b_route = pin_b.route;
   assign o_sense_out_pin_b_gain = pin_b.gain;
   assign o_sense_out_pin_b_oe_n = pin_b.oe_n;
   assign o_sense_out_pin_b_reserved = pin_b.reserved_sel;

   // ****************************************************************
   // channel-4 comparator feedbacks
   // ****************************************************************
   // no flop here: the microcores sample these themselves, and a
   // register would only add a cycle of detection delay
   // strict greater-than with no hysteresis band, so every crossing shows
   assign o_chan_four_negative_feedback =
      (i_diff_amp_level > i_neg_dac_level);
   assign o_chan_four_high_feedback = i_chan_four_high_cmp;
   assign o_chan_four_low_feedback = i_chan_four_low_cmp;

endmodule : som_top
`default_nettype wire

/* File: som_top_chk.sv */
// port assertions for the sense output mux control
`timescale 1ns/1ps
`default_nettype none
`include "som_defs.svh"
module som_top_chk #(
   parameter int LEVEL_W = 12
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_core_wr_en,
   input wire logic i_core_sel_b,
   input wire logic [8:0] i_core_addr,
   input wire logic [15:0] i_core_wr_data,
   input wire logic [LEVEL_W-1:0] i_diff_amp_level,
   input wire logic [LEVEL_W-1:0] i_neg_dac_level,
   input wire logic i_chan_four_high_cmp,
   input wire logic i_chan_four_low_cmp,
   input wire logic o_chan_four_high_feedback,
   input wire logic o_chan_four_low_feedback,
   input wire logic o_chan_four_negative_feedback,
   input wire logic [1:0] o_sense_out_pin_a_route,
   input wire logic [1:0] o_sense_out_pin_a_gain,
   input wire logic o_sense_out_pin_a_oe_n,
   input wire logic o_sense_out_pin_a_reserved,
   input wire logic [1:0] o_sense_out_pin_b_route,
   input wire logic [1:0] o_sense_out_pin_b_gain,
   input wire logic o_sense_out_pin_b_oe_n,
   input wire logic o_sense_out_pin_b_reserved
);
   logic [15:0] cfg_a_q;
   logic [15:0] cfg_b_q;
   logic wr_ok;
   logic gt;
   logic [3:0] exp_a;
   logic [3:0] exp_b;
   logic [3:0] gains;
   // reserved codes fall back to off, so route 0 with oe_n high
   function automatic logic [3:0] pin_exp(input logic [15:0] c);
      logic on;
      on = c[3] && (c[2:0] == 3'h0 || c[2:0] == 3'h1 || c[2:0] == 3'h5);
      pin_exp = {!on, c[3] && !on, on ? 2'h3 : 2'h0};
      if (on && c[2:0] != 3'h5) begin
         pin_exp[1:0] = c[1:0] + 2'h1;
      end
   endfunction : pin_exp
   assign wr_ok = i_core_wr_en && i_core_addr == `SOM_CFG_OFFSET;
   assign gt = i_diff_amp_level > i_neg_dac_level;
   assign exp_a = pin_exp(cfg_a_q);
   assign exp_b = pin_exp(cfg_b_q);
   assign gains = {cfg_a_q[5:4], cfg_b_q[5:4]};
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cfg_a_q <= 16'h0000;
         cfg_b_q <= 16'h0000;
      end else if (wr_ok && i_core_sel_b) begin
         cfg_b_q <= i_core_wr_data;
      end else if (wr_ok) begin
         cfg_a_q <= i_core_wr_data;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   property p_neg; o_chan_four_negative_feedback == gt; endproperty
   a_neg: assert property (p_neg) else $error("neg feedback");
   property p_hys; $changed(gt) |-> $changed(o_chan_four_negative_feedback);
   endproperty
   a_hys: assert property (p_hys) else $error("neg no toggle");
   property p_fbk; {o_chan_four_high_feedback, o_chan_four_low_feedback} ==
      {i_chan_four_high_cmp, i_chan_four_low_cmp}; endproperty
   a_fbk: assert property (p_fbk) else $error("ch4 feedback");
   property p_gain; {o_sense_out_pin_a_gain, o_sense_out_pin_b_gain} ==
      $past(gains); endproperty
   a_gain: assert property (p_gain) else $error("gain");
   property p_pina; {o_sense_out_pin_a_oe_n, o_sense_out_pin_a_reserved,
      o_sense_out_pin_a_route} == $past(exp_a); endproperty
   a_pina: assert property (p_pina) else $error("pin a");
   property p_pinb; {o_sense_out_pin_b_oe_n, o_sense_out_pin_b_reserved,
      o_sense_out_pin_b_route} == $past(exp_b); endproperty
   a_pinb: assert property (p_pinb) else $error("pin b");
   property p_off; !cfg_b_q[3] |=> o_sense_out_pin_b_oe_n &&
      o_sense_out_pin_b_route == 2'h0; endproperty
   a_off: assert property (p_off) else $error("pin b not off");
   property p_rst; $rose(i_resetn) |-> o_sense_out_pin_a_oe_n &&
      o_sense_out_pin_b_oe_n; endproperty
   a_rst: assert property (p_rst) else $error("reset enable");
endmodule : som_top_chk
bind som_top som_top_chk #(.LEVEL_W(LEVEL_W)) u_chk (.*);
`default_nettype wire

/* File: som_adc_model.sv */
// adc input shared by both sense output pins
`timescale 1ns/1ps
`default_nettype none
module som_adc_model (
   input wire logic i_a_oe_n,
   input wire logic i_b_oe_n,
   input wire logic [1:0] i_a_route,
   input wire logic [1:0] i_b_route,
   output logic [2:0] o_seen
);
   // idle line sits at the pull-down; two drivers show as 7
   assign o_seen = (!i_a_oe_n && !i_b_oe_n) ? 3'h7 :
      !i_a_oe_n ? {1'b0, i_a_route} :
      !i_b_oe_n ? {1'b0, i_b_route} + 3'h3 : 3'h0;
endmodule : som_adc_model
`default_nettype wire

/* File: tb_sense_output_mux_control.sv */
// self-checking bench for the sense output mux control
`timescale 1ns/1ps
`default_nettype none
module tb_sense_output_mux_control;
   logic i_clk, i_resetn, i_core_wr_en, i_core_rd_en, i_core_sel_b;
   logic i_chan_four_high_cmp, i_chan_four_low_cmp, o_core_rd_valid;
   logic o_chan_four_high_feedback, o_chan_four_low_feedback;
   logic o_chan_four_negative_feedback;
   logic o_sense_out_pin_a_oe_n, o_sense_out_pin_a_reserved;
   logic o_sense_out_pin_b_oe_n, o_sense_out_pin_b_reserved;
   logic [1:0] o_sense_out_pin_a_route, o_sense_out_pin_a_gain;
   logic [1:0] o_sense_out_pin_b_route, o_sense_out_pin_b_gain;
   logic [8:0] i_core_addr;
   logic [11:0] i_diff_amp_level, i_neg_dac_level;
   logic [15:0] i_core_wr_data, o_core_rd_data;
   logic [2:0] seen;
   int error_cnt = 0;
   int compares = 0;
   som_top DUT (.*);
   som_adc_model u_adc (.i_a_oe_n(o_sense_out_pin_a_oe_n),
      .i_b_oe_n(o_sense_out_pin_b_oe_n), .i_a_route(o_sense_out_pin_a_route),
      .i_b_route(o_sense_out_pin_b_route), .o_seen(seen));
   always #2 i_clk = ~i_clk;
   // wide enough for rd_valid on top of a full read word
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      if (error_cnt == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // one strobe cycle; a read leaves rd_valid up for the caller to see
   task automatic bus(input logic wr, input logic sel, input logic [8:0] a,
      input logic [15:0] d);
      @(negedge i_clk);
      i_core_wr_en = wr;
      i_core_rd_en = !wr;
      i_core_sel_b = sel;
      i_core_addr = a;
      i_core_wr_data = d;
      @(negedge i_clk);
      i_core_wr_en = 0;
      i_core_rd_en = 0;
   endtask : bus
   task automatic t_reset();
      chk({o_sense_out_pin_a_oe_n, o_sense_out_pin_b_oe_n}, 16'h0003);
      bus(0, 1, 9'h1aa, 16'h0000);
      chk({o_core_rd_valid, o_core_rd_data}, 17'h10000);
   endtask : t_reset
   task automatic t_pins();
      logic [15:0] d;
      logic on;
      logic [1:0] rt;
      for (int i = 0; i < 32; i++) begin
         d = {10'h000, i[1:0], i[3], i[2:0]};
         on = i[3] && (i[2:0] == 0 || i[2:0] == 1 || i[2:0] == 5);
         rt = !on ? 2'h0 : (i[2:0] == 5) ? 2'h3 : i[1:0] + 2'h1;
         bus(1, i[4], 9'h1aa, d);
         @(negedge i_clk);
         chk(i[4] ? {o_sense_out_pin_b_gain, o_sense_out_pin_b_oe_n,
            o_sense_out_pin_b_reserved, o_sense_out_pin_b_route} :
            {o_sense_out_pin_a_gain, o_sense_out_pin_a_oe_n,
            o_sense_out_pin_a_reserved, o_sense_out_pin_a_route},
            {i[1:0], !on, i[3] && !on, rt});
         chk(seen, on ? rt + (i[4] ? 3 : 0) : 0);
         bus(0, i[4], 9'h1aa, 16'h0000);
         chk(o_core_rd_data, d);
      end
   endtask : t_pins
   task automatic t_unmapped();
      bus(1, 0, 9'h1ab, 16'h0009);
      bus(0, 0, 9'h1ab, 16'h0000);
      chk({o_core_rd_valid, o_core_rd_data}, 17'h10000);
      bus(0, 0, 9'h1aa, 16'h0000);
      chk(o_core_rd_data, 16'h003f);
   endtask : t_unmapped
   task automatic t_cmp();
      for (int k = 0; k < 6; k++) begin
         @(negedge i_clk);
         i_diff_amp_level = 12'h063 + ((k < 3) ? k : 5 - k);
         i_chan_four_high_cmp = k[0];
         i_chan_four_low_cmp = k[1];
         #1;
         chk(o_chan_four_negative_feedback, k == 2 || k == 3);
         chk({o_chan_four_high_feedback, o_chan_four_low_feedback},
            {k[0], k[1]});
      end
   endtask : t_cmp
   initial begin
      #20000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      {i_clk, i_resetn, i_core_wr_en, i_core_rd_en, i_core_sel_b} = 0;
      {i_chan_four_high_cmp, i_chan_four_low_cmp} = 0;
      i_core_addr = 9'h000;
      i_core_wr_data = 16'h0000;
      i_diff_amp_level = 12'h000;
      i_neg_dac_level = 12'h064;
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      i_resetn = 1;
      t_reset();
      t_pins();
      t_unmapped();
      t_cmp();
      wrap_up();
   end
endmodule : tb_sense_output_mux_control
`default_nettype wire
